// ===== cbo_pkg.sv
// Shared constants and types of the corrected block output scheduler
package cbo_pkg;

  // Block and frame geometry
  localparam int BLK_W      = 272;
  localparam int FRM_BLKS   = 272;
  localparam int DATA_BLKS  = 190;
  localparam int SLOT_FIRST = 29;
  localparam int SLOT_LAST  = 218;
  localparam int NUM_W      = 8;
  localparam int IDX_W      = 9;

  // Time-division of one block period
  localparam int T_HALF_MS  = 9;
  localparam int CLK_NS     = 10;
  localparam int NS_PER_MS  = 1000000;
  localparam int TMR_W      = 20;

  // One block as it sits in the output buffer
  typedef struct packed {
    logic [BLK_W-1:0] data;
    logic [NUM_W-1:0] num;
    logic             vh;
    logic             blk;
    logic             frm;
    logic             err;
    logic             pri;
    logic             head;
  } cbo_entry_t;

  // Whole state of the scheduler
  typedef struct packed {
    logic                 int_n;
    cbo_entry_t           obuf;
    cbo_entry_t           stg;
    logic                 stg_v;
    logic [DATA_BLKS-1:0] fail_cur;
    logic [DATA_BLKS-1:0] fail_prv;
    logic                 any_cur;
    logic                 any_prv;
    logic                 frm_cur;
    logic                 stored;
    logic                 vc_run;
    logic                 vc_fin;
    logic                 vc_start;
    logic [IDX_W-1:0]     rx_idx;
    logic [TMR_W-1:0]     tmr;
    logic                 tarm;
    logic [NUM_W-1:0]     slot;
    logic                 vreq;
  } cbo_state_t;

  localparam cbo_state_t ST_RST = '{int_n: 1'b1, default: '0};

  // True when v lies in lo..hi inclusive
  function automatic logic in_span(input int v, input int lo, input int hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction : in_span

endpackage : cbo_pkg

// ===== cbo_pol_if.sv
// Carrier between the scheduler core and its output policy
`timescale 1ns/1ps
interface cbo_pol_if;
  logic int_move;
  logic frame_output_select;
  logic h_ok;
  logic h_blk;
  logic h_frm;
  logic h_par;
  logic v_fin;
  logic v_fail;
  logic v_any;
  logic v_ok;
  logic h_take;
  logic v_arm;
  logic v_take;

  modport core (output int_move, frame_output_select, h_ok, h_blk, h_frm,
                output h_par, v_fin, v_fail, v_any, v_ok,
                input  h_take, v_arm, v_take);
  modport pol  (input  int_move, frame_output_select, h_ok, h_blk, h_frm,
                input  h_par, v_fin, v_fail, v_any, v_ok,
                output h_take, v_arm, v_take);
endinterface : cbo_pol_if

// ===== cbo_policy.sv
// Output selection policy for the two mode bits
`timescale 1ns/1ps
module cbo_policy (
  cbo_pol_if.pol p
);
  // Horizontal result: all of them when timing is moved
  assign p.h_take = p.int_move |
                    (p.h_ok & p.h_blk & p.h_frm & ~p.h_par); // see R2 R3 R19

  // May a frame slot ask the correction engine at all
  always_comb begin
    if (p.frame_output_select) begin
      p.v_arm = 1'b1;                           // see R8 R19
    end else if (p.int_move) begin
      p.v_arm = p.v_any;                        // see R20
    end else begin
      p.v_arm = p.v_fin & p.v_fail;             // see R5 R8 R17
    end
  end

  // Default mode keeps only fully repaired blocks
  assign p.v_take = p.v_arm &
                    (p.int_move | p.frame_output_select | p.v_ok); // see R5
endmodule : cbo_policy

// ===== cbo_sched.sv
// Corrected block output scheduler: output buffer, request and frame slots
//
// How it works
// R1 - Each 272-bit block is CRC checked and corrected, then offered.
// R2 - Default: offer block only if correct, in both syncs, and data.
// R3 - Mode bits may offer horizontal results failing those conditions.
// R4 - Frame correction follows when per-block correction leaves errors.
// R5 - Default frame output: only data blocks repaired by frame correction.
// R6 - Start frame correction only for stored, synced frame with failures.
// R7 - Blocks already good are locked against frame correction.
// R8 - Default: no frame output unless correction ran; modes may force it.
// R9 - One output buffer; every new result overwrites it.
// R10 - Request falls low when a buffered block is ready.
// R11 - Host reads within about 9ms, or 18ms with per-block only.
// R12 - Block period splits into per-block part and frame part.
// R13 - One block per request; frame blocks in order, parity skipped.
// R14 - Block N result is offered while block N+1 arrives.
// R15 - Frame N-1 correction starts at head of frame N.
// R16 - 190 frame slots, one per block, from block 29 to 218.
// R17 - Slot of an unsent block raises nothing; slots never shift.
// R18 - Timing-move and frame-output bits set timing and content; here both bits change content only, the slot timer is the same in every mode.
// R19 - Timing moved: failed and parity blocks too; both bits: all 190.
// R20 - Timing moved only: frame output only if some block failed.
// R21 - Host reads status first and may skip the block.
// R22 - Request rises before the buffer is overwritten.
`timescale 1ns/1ps
module cbo_sched #(
  parameter int HALF_CYC = cbo_pkg::T_HALF_MS * cbo_pkg::NS_PER_MS
                           / cbo_pkg::CLK_NS
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Mode bits from the host side configuration
  input  wire logic                        int_move,
  input  wire logic                        frame_output_select,
  // Per-block corrector result
  input  wire logic                        hc_done,
  input  wire logic [cbo_pkg::BLK_W-1:0]   hc_data,
  input  wire logic                        hc_ok,
  input  wire logic                        hc_blk_sync,
  input  wire logic                        hc_frm_sync,
  input  wire logic                        hc_parity,
  input  wire logic                        hc_head,
  input  wire logic [cbo_pkg::NUM_W-1:0]   hc_num,
  // Frame correction engine
  output logic                             vc_start,
  input  wire logic                        vc_done,
  input  wire logic [cbo_pkg::NUM_W-1:0]   vc_q_idx,
  output logic                             vc_q_lock,
  output logic                             vc_rd_req,
  output logic [cbo_pkg::NUM_W-1:0]        vc_rd_idx,
  input  wire logic                        vc_rd_valid,
  input  wire logic [cbo_pkg::BLK_W-1:0]   vc_rd_data,
  input  wire logic                        vc_rd_ok,
  // Host side of the output buffer
  input  wire logic                        rd_ack,
  output logic                             int_n,
  output logic [cbo_pkg::BLK_W-1:0]        out_data,
  output logic [cbo_pkg::NUM_W-1:0]        out_num,
  output logic                             out_vh,
  output logic                             out_blk,
  output logic                             out_frm,
  output logic                             out_err,
  output logic                             out_pri,
  output logic                             out_head
);

  localparam logic [cbo_pkg::TMR_W-1:0] HALF_T = HALF_CYC[cbo_pkg::TMR_W-1:0];
  localparam logic [cbo_pkg::TMR_W-1:0] TMR_ONE = 20'h00001;
  localparam logic [cbo_pkg::IDX_W-1:0] IDX_ONE = 9'h001;
  localparam logic [cbo_pkg::IDX_W-1:0] IDX_FULL =
    cbo_pkg::FRM_BLKS[cbo_pkg::IDX_W-1:0];
  localparam logic [cbo_pkg::IDX_W-1:0] IDX_SAT =
    IDX_FULL + IDX_ONE;
  localparam logic [cbo_pkg::IDX_W-1:0] IDX_SLOT0 =
    cbo_pkg::SLOT_FIRST[cbo_pkg::IDX_W-1:0];

  cbo_pkg::cbo_state_t st_ff;
  cbo_pkg::cbo_state_t nxt_st;
  logic [cbo_pkg::IDX_W-1:0] idx;

  cbo_pol_if pol ();

  cbo_policy u_policy (
    .p (pol.pol)
  );

  // Policy inputs from the current block and the previous frame
  assign pol.int_move            = int_move;            // see R18
  assign pol.frame_output_select = frame_output_select; // see R18
  assign pol.h_ok                = hc_ok;
  assign pol.h_blk               = hc_blk_sync;
  assign pol.h_frm               = hc_frm_sync;
  assign pol.h_par               = hc_parity;
  assign pol.v_fin               = st_ff.vc_fin;
  assign pol.v_fail              = cbo_pkg::in_span(int'(st_ff.slot), 0,
                                     cbo_pkg::DATA_BLKS - 1) &&
                                   st_ff.fail_prv[st_ff.slot];
  assign pol.v_any               = st_ff.any_prv;
  assign pol.v_ok                = vc_rd_ok;

  // Next state
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.vc_start = 1'b0;
    nxt_st.vreq     = 1'b0;
    idx             = st_ff.rx_idx;

    // Engine reports the previous frame finished
    if (vc_done) begin
      nxt_st.vc_run = 1'b0;
      nxt_st.vc_fin = 1'b1;
    end

    // Second half of a block period hosts the frame slot
    if (st_ff.tarm) begin
      if (st_ff.tmr != '0) begin
        nxt_st.tmr = st_ff.tmr - TMR_ONE;
      end else begin
        nxt_st.tarm = 1'b0;
        nxt_st.vreq = pol.v_arm;                // see R12 R17
      end
    end

    // Block bookkeeping on each per-block result
    if (hc_done) begin
      if (hc_head) begin
        idx = IDX_ONE;
      end else if (st_ff.rx_idx != IDX_SAT) begin
        idx = st_ff.rx_idx + IDX_ONE;
      end
      nxt_st.rx_idx = idx;
      if (hc_head) begin
        // Previous frame becomes the one under frame correction
        nxt_st.stored   = (st_ff.rx_idx == IDX_FULL);
        nxt_st.fail_prv = st_ff.fail_cur;
        nxt_st.any_prv  = st_ff.any_cur;
        nxt_st.fail_cur = '0;
        nxt_st.any_cur  = 1'b0;
        nxt_st.frm_cur  = 1'b1;
        nxt_st.vc_fin   = 1'b0;
        if ((st_ff.rx_idx == IDX_FULL) && st_ff.frm_cur &&
            st_ff.any_cur) begin
          nxt_st.vc_start = 1'b1;               // see R4 R6 R15
          nxt_st.vc_run   = 1'b1;
        end
      end
      if (!hc_frm_sync) begin
        nxt_st.frm_cur = 1'b0;                  // see R6
      end
      if (!hc_ok && !hc_parity &&
          cbo_pkg::in_span(int'(hc_num), 0, cbo_pkg::DATA_BLKS - 1)) begin
        nxt_st.any_cur          = 1'b1;
        nxt_st.fail_cur[hc_num] = 1'b1;         // see R7
      end
      // Fixed slot per received block, never pulled earlier
      if (cbo_pkg::in_span(int'(idx), cbo_pkg::SLOT_FIRST,
                           cbo_pkg::SLOT_LAST)) begin
        nxt_st.tarm = 1'b1;                     // see R16 R17
        nxt_st.tmr  = HALF_T - TMR_ONE;
        nxt_st.slot = 8'(idx - IDX_SLOT0);      // see R13
      end
    end

    // Host acknowledge ends the request
    if (rd_ack) begin
      nxt_st.int_n = 1'b1;
    end

    // Stage drains into the buffer, request high one cycle first
    if (st_ff.stg_v) begin
      if (!st_ff.int_n) begin
        nxt_st.int_n = 1'b1;                    // see R22
      end else begin
        nxt_st.obuf  = st_ff.stg;               // see R9
        nxt_st.int_n = 1'b0;                    // see R10 R13
        nxt_st.stg_v = 1'b0;
      end
    end

    // New results overwrite the stage
    if (hc_done && pol.h_take) begin
      nxt_st.stg.data = hc_data;                // see R1 R14
      nxt_st.stg.num  = hc_num;
      nxt_st.stg.vh   = 1'b0;
      nxt_st.stg.blk  = hc_blk_sync;
      nxt_st.stg.frm  = hc_frm_sync;
      nxt_st.stg.err  = ~hc_ok;
      nxt_st.stg.pri  = hc_parity;
      nxt_st.stg.head = hc_head;
      nxt_st.stg_v    = 1'b1;
    end else if (vc_rd_valid && pol.v_take) begin
      nxt_st.stg.data = vc_rd_data;             // see R5 R19 R20
      nxt_st.stg.num  = st_ff.slot;
      nxt_st.stg.vh   = 1'b1;
      nxt_st.stg.blk  = 1'b1;
      nxt_st.stg.frm  = 1'b1;
      nxt_st.stg.err  = ~vc_rd_ok;
      nxt_st.stg.pri  = 1'b0;
      nxt_st.stg.head = (st_ff.slot == '0);
      nxt_st.stg_v    = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff <= cbo_pkg::ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state
  assign int_n     = st_ff.int_n;
  assign out_data  = st_ff.obuf.data;
  assign out_num   = st_ff.obuf.num;
  assign out_vh    = st_ff.obuf.vh;
  assign out_blk   = st_ff.obuf.blk;
  assign out_frm   = st_ff.obuf.frm;
  assign out_err   = st_ff.obuf.err;
  assign out_pri   = st_ff.obuf.pri;
  assign out_head  = st_ff.obuf.head;
  assign vc_start  = st_ff.vc_start;
  assign vc_rd_req = st_ff.vreq;
  assign vc_rd_idx = st_ff.slot;
  // Good blocks of the previous frame are locked
  assign vc_q_lock = !(cbo_pkg::in_span(int'(vc_q_idx), 0,
                       cbo_pkg::DATA_BLKS - 1) &&
                       st_ff.fail_prv[vc_q_idx]);  // see R7

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_req;
    vc_rd_req;
  endsequence

  sequence s_quiet;
    !vc_rd_req [*2];
  endsequence

  request_high_first_a: assert property ( // see R22
    (st_ff.stg_v && !int_n) |=> int_n)
    else $error("request not raised before overwrite");

  request_on_load_a: assert property ( // see R10
    $fell(int_n) |-> $past(st_ff.stg_v) && $past(int_n))
    else $error("request fell without a staged block");

  horiz_default_a: assert property ( // see R2
    ($fell(int_n) && !out_vh && !$past(int_move, 2)) |->
      (!out_err && out_blk && out_frm && !out_pri))
    else $error("default horizontal output broke its conditions");

  vert_default_a: assert property ( // see R5
    ($fell(int_n) && out_vh && !$past(int_move, 2) &&
     !$past(frame_output_select, 2)) |-> (!out_err && !out_pri))
    else $error("default frame output not a repaired data block");

  frame_start_a: assert property ( // see R6
    vc_start |-> (st_ff.any_prv && st_ff.stored && $past(hc_head)))
    else $error("frame correction started without cause");

  slot_window_a: assert property ( // see R16
    s_req |-> cbo_pkg::in_span(int'(st_ff.rx_idx), cbo_pkg::SLOT_FIRST,
                               cbo_pkg::SLOT_LAST))
    else $error("frame slot outside blocks 29 to 218");

  slot_spacing_a: assert property ( // see R12
    s_req |=> s_quiet)
    else $error("two frame slots too close");

  slot_index_a: assert property ( // see R13
    s_req |-> (vc_rd_idx == 8'(st_ff.rx_idx - IDX_SLOT0)))
    else $error("frame slot out of order");

  ack_release_a: assert property ( // see R10
    (rd_ack && !st_ff.stg_v && !int_n) |=> int_n)
    else $error("acknowledge did not release the request");

  lock_good_a: assert property ( // see R7
    (cbo_pkg::in_span(int'(vc_q_idx), 0, cbo_pkg::DATA_BLKS - 1) &&
     !st_ff.fail_prv[vc_q_idx]) |-> vc_q_lock)
    else $error("good block left open to frame correction");

endmodule : cbo_sched

// ===== cbo_host_model.sv
// Host reader model that answers each transfer request of the scheduler
`timescale 1ns/1ps
module cbo_host_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       int_n,
  input  wire logic       out_vh,
  input  wire logic [7:0] out_num,
  input  wire logic       slow,
  output logic            rd_ack,
  output int              n_req,
  output int              n_vh,
  output int              n_glitch,
  output logic [7:0]      vh_num
);
  logic       int_q;
  logic [7:0] num_q;
  int         wait_c;

  initial begin
    rd_ack = 1'b0;
    n_req = 0;
    n_vh = 0;
    n_glitch = 0;
    vh_num = 8'h00;
    int_q = 1'b1;
    num_q = 8'h00;
    wait_c = 0;
  end

  // Status is read on each new request, the block is released later
  always @(negedge ref_clk) begin
    if (rst_n && !int_n && int_q) begin
      n_req++;
      wait_c = slow ? 40 : 3;
      if (out_vh) begin
        n_vh++;
        vh_num = out_num;
      end
    end else if (rst_n && !int_n && out_num !== num_q) begin
      n_glitch++;  // Buffer changed under a standing request
    end
    rd_ack = rst_n && !int_n && !int_q && wait_c == 1;
    if (wait_c > 0) wait_c--;
    int_q = int_n;
    num_q = out_num;
  end
endmodule : cbo_host_model

// ===== testbench.sv
// Self-checking bench of the corrected block output scheduler
`timescale 1ns/1ps
module testbench;
  localparam int HC = 20;
  typedef struct packed {
    logic im; logic ok; logic bs; logic fs; logic par; logic exp;
  } cbo_row_t;
  // Mode, status bits and whether a request should follow
  cbo_row_t rows [6] = '{'{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1},
                         '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
                         '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
                         '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0},
                         '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
                         '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}};
  logic ref_clk = 1'b0, rst_n = 1'b0, slow = 1'b0;
  logic int_move = 1'b0, frame_output_select = 1'b0;
  logic hc_done = 1'b0, hc_ok = 1'b0, hc_parity = 1'b0, hc_head = 1'b0;
  logic hc_blk_sync = 1'b0, hc_frm_sync = 1'b0;
  logic [7:0] hc_num = 8'h00;
  logic [cbo_pkg::BLK_W-1:0] hc_data = '0, vc_rd_data = '0, out_data;
  logic vc_done = 1'b0, vc_rd_valid = 1'b0, vc_rd_ok = 1'b1, vc_q_lock;
  logic [7:0] vc_q_idx = 8'h00;
  logic vc_start, vc_rd_req, rd_ack, int_n;
  logic out_vh, out_blk, out_frm, out_err, out_pri, out_head;
  logic [7:0] vc_rd_idx, out_num, vh_num, vidx;
  int n_req, n_vh, n_glitch, n_fail = 0, checks_done = 0;
  int n_vst = 0, n_vreq = 0, cur_i = 0, vblk = 0, r0;

  always #5 ref_clk = ~ref_clk;

  cbo_sched #(.HALF_CYC(HC)) cbo_sched_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .int_move(int_move),
    .frame_output_select(frame_output_select), .hc_done(hc_done),
    .hc_data(hc_data), .hc_ok(hc_ok), .hc_blk_sync(hc_blk_sync),
    .hc_frm_sync(hc_frm_sync), .hc_parity(hc_parity), .hc_head(hc_head),
    .hc_num(hc_num), .vc_start(vc_start), .vc_done(vc_done),
    .vc_q_idx(vc_q_idx), .vc_q_lock(vc_q_lock), .vc_rd_req(vc_rd_req),
    .vc_rd_idx(vc_rd_idx), .vc_rd_valid(vc_rd_valid),
    .vc_rd_data(vc_rd_data), .vc_rd_ok(vc_rd_ok), .rd_ack(rd_ack),
    .int_n(int_n), .out_data(out_data), .out_num(out_num),
    .out_vh(out_vh), .out_blk(out_blk), .out_frm(out_frm),
    .out_err(out_err), .out_pri(out_pri), .out_head(out_head));

  cbo_host_model cbo_host_model_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .int_n(int_n), .out_vh(out_vh),
    .out_num(out_num), .slow(slow), .rd_ack(rd_ack), .n_req(n_req),
    .n_vh(n_vh), .n_glitch(n_glitch), .vh_num(vh_num));

  // Frame correction engine stand-in: answers each fetch a cycle later
  always @(negedge ref_clk) begin
    vc_done <= vc_start;
    vc_rd_valid <= vc_rd_req;
    vc_rd_data <= {34{vc_rd_idx}};
    if (vc_start) n_vst++;
    if (vc_rd_req) begin
      n_vreq++;
      vidx = vc_rd_idx;
      vblk = cur_i;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One corrected block result, next one gap cycles later
  task automatic blk(input logic [7:0] n, input logic ok, bs, fs, par, hd,
                     input int gap);
    @(negedge ref_clk);
    hc_done = 1'b1;
    hc_num = n;
    hc_data = {34{n}};
    hc_ok = ok;
    hc_blk_sync = bs;
    hc_frm_sync = fs;
    hc_parity = par;
    hc_head = hd;
    @(negedge ref_clk);
    hc_done = 1'b0;
    repeat (gap - 2) @(negedge ref_clk);
  endtask : blk

  // Whole 272-block frame in sync, one failed data block if fail >= 0
  task automatic run_frame(input logic im, fos, input int fail, st, vr, vh);
    int s0, q0, h0;
    s0 = n_vst;
    q0 = n_vreq;
    h0 = n_vh;
    int_move = im;
    frame_output_select = fos;
    for (int i = 1; i <= 272; i++) begin
      cur_i = i;
      blk(i <= 190 ? 8'(i - 1) : 8'(i - 191), (i - 1) != fail, 1'b1, 1'b1,
          i > 190, i == 1, 30);
    end
    repeat (40) @(negedge ref_clk);
    chk(n_vst - s0, st);
    chk(n_vreq - q0, vr);
    chk(n_vh - h0, vh);
  endtask : run_frame

  task automatic report_and_stop();
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond four frames of traffic
  initial begin
    #(50000 * 10);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(negedge ref_clk);
    chk(int_n, 1'b1);
    chk(out_num, 8'h00);
    chk(vc_start, 1'b0);
    rst_n = 1'b1;
    // Per-block offer decisions
    foreach (rows[k]) begin
      r0 = n_req;
      int_move = rows[k].im;
      blk(8'(k + 16), rows[k].ok, rows[k].bs, rows[k].fs, rows[k].par,
          1'b0, 12);
      chk(n_req - r0, rows[k].exp);
      if (rows[k].exp) begin
        chk(out_num, k + 16);
        chk(out_data === {34{8'(k + 16)}}, 1'b1);
        chk(out_err, !rows[k].ok);
      end
    end
    // Slow host, second result three cycles after the first
    int_move = 1'b0;
    slow = 1'b1;
    r0 = n_req;
    blk(8'h0a, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3);
    blk(8'h0b, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8);
    chk(n_req - r0, 2);
    chk(out_num, 8'h0b);
    chk(n_glitch, 0);
    repeat (40) @(negedge ref_clk);
    chk(int_n, 1'b1);
    slow = 1'b0;
    // Frames: failure, default repair, timing moved, both bits set
    run_frame(1'b0, 1'b0, 5, 0, 0, 0);
    run_frame(1'b0, 1'b0, -1, 1, 1, 1);
    chk(vh_num, 8'h05);
    chk(vidx, 8'h05);
    chk(vblk, 34);
    // Failed block 5 of the stored frame stays open, block 6 is locked
    @(negedge ref_clk);
    vc_q_idx = 8'h05;
    #1;
    chk(vc_q_lock, 1'b0);
    vc_q_idx = 8'h06;
    #1;
    chk(vc_q_lock, 1'b1);
    run_frame(1'b1, 1'b0, -1, 0, 0, 0);
    // Both bits set: unrepaired frame results are still offered
    vc_rd_ok = 1'b0;
    run_frame(1'b1, 1'b1, -1, 0, 190, 190);
    chk(n_glitch, 0);
    report_and_stop();
  end
endmodule : testbench
